// ---- shared/orrx_pkg.sv ----
// Constants and types shared by the OR, return and rotate execution block.
package orrx_pkg;

  localparam int          DATA_W    = 8;
  localparam int          PC_W_DEF  = 12;
  localparam int          MSB_POS   = 7;
  localparam int          LSB_POS   = 0;
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic        ZERO_RST  = 1'b0;
  localparam logic        MIE_RST   = 1'b0;
  localparam logic        MIE_SET   = 1'b1;

  typedef enum logic [2:0] {
    OP_IDLE_INSTRUCTION      = 3'b000,
    OP_OR_MEM_TO_ACC         = 3'b001,
    OP_OR_IMM_TO_ACC         = 3'b010,
    OP_LOGICAL_OR_TO_MEMORY  = 3'b011,
    OP_SUBROUTINE_EXIT       = 3'b100,
    OP_SUBROUTINE_EXIT_VALUE = 3'b101,
    OP_INTERRUPT_EXIT        = 3'b110,
    OP_ROTATE_LEFT_MEMORY    = 3'b111
  } orrx_op_t;

endpackage : orrx_pkg

// ---- shared/orrx_alu_if.sv ----
// Carrier between the execution core and its data path.
`timescale 1ns/1ps
interface orrx_alu_if;
  logic [7:0]       acc;
  logic [7:0]       mem;
  logic [7:0]       imm;
  orrx_pkg::orrx_op_t op;
  logic [7:0]       result;
  logic             zero;
  logic             acc_we;
  logic             mem_we;
  logic             zero_we;

  modport core (
    output acc,
    output mem,
    output imm,
    output op,
    input  result,
    input  zero,
    input  acc_we,
    input  mem_we,
    input  zero_we
  );

  modport alu (
    input  acc,
    input  mem,
    input  imm,
    input  op,
    output result,
    output zero,
    output acc_we,
    output mem_we,
    output zero_we
  );
endinterface : orrx_alu_if

// ---- logic/orrx_alu.sv ----
// Combinational data path: OR forms, rotate left, immediate load and zero test.
`timescale 1ns/1ps
module orrx_alu (
  orrx_alu_if.alu dp
);

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == orrx_pkg::BYTE_ZERO);
  endfunction : is_zero

  always_comb begin
    dp.result  = orrx_pkg::BYTE_ZERO;
    dp.acc_we  = 1'b0;
    dp.mem_we  = 1'b0;
    dp.zero_we = 1'b0;
    unique case (dp.op)
      orrx_pkg::OP_IDLE_INSTRUCTION: begin
        dp.result = dp.acc; // RL1
      end
      orrx_pkg::OP_OR_MEM_TO_ACC: begin
        dp.result  = dp.acc | dp.mem; // RL2
        dp.acc_we  = 1'b1;
        dp.zero_we = 1'b1;
      end
      orrx_pkg::OP_OR_IMM_TO_ACC: begin
        dp.result  = dp.acc | dp.imm; // RL3
        dp.acc_we  = 1'b1;
        dp.zero_we = 1'b1;
      end
      orrx_pkg::OP_LOGICAL_OR_TO_MEMORY: begin
        dp.result  = dp.acc | dp.mem; // RL4
        dp.mem_we  = 1'b1;
        dp.zero_we = 1'b1;
      end
      orrx_pkg::OP_SUBROUTINE_EXIT: begin
        dp.result = dp.acc; // RL5
      end
      orrx_pkg::OP_SUBROUTINE_EXIT_VALUE: begin
        dp.result = dp.imm; // RL6
        dp.acc_we = 1'b1;
      end
      orrx_pkg::OP_INTERRUPT_EXIT: begin
        dp.result = dp.acc; // RL7
      end
      orrx_pkg::OP_ROTATE_LEFT_MEMORY: begin
        dp.result = {dp.mem[orrx_pkg::MSB_POS-1:orrx_pkg::LSB_POS],
                     dp.mem[orrx_pkg::MSB_POS]}; // RL9
        dp.mem_we = 1'b1;
      end
    endcase
  end

  assign dp.zero = is_zero(dp.result); // RL10

endmodule : orrx_alu

// ---- logic/orrx_exec.sv ----
// Execution core for the OR, return and rotate instructions.
`timescale 1ns/1ps
// Overview of operation
// RL1: The idle instruction changes no register, memory byte or flag and just lets fetch go on.
// RL2: OR memory to accumulator writes accumulator OR memory byte into the accumulator and updates only the zero flag.
// RL3: OR immediate writes accumulator OR immediate operand into the accumulator and updates only the zero flag.
// RL4: OR into memory writes accumulator OR memory byte back to memory, keeps the accumulator and updates only the zero flag.
// RL5: Subroutine exit pops the stack top into the program counter and alters no flag.
// RL6: Exit with value pops the program counter and loads the immediate into the accumulator, altering no flag.
// RL7: Interrupt exit pops the program counter and sets the master interrupt enable to one, altering no status flag.
// RL8: A request already pending at interrupt exit is serviced before the interrupted program resumes.
// RL9: Rotate left moves the memory byte one place toward bit 7 with bit 7 wrapping into bit 0, altering no flag.
// RL10: Whenever the zero flag is updated it is set for an all-zero result and cleared otherwise.
module orrx_exec #(
  parameter int PC_W = orrx_pkg::PC_W_DEF
) (
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               exec_valid_i,
  input  wire orrx_pkg::orrx_op_t exec_op_i,
  input  wire logic [7:0]         exec_imm_i,
  input  wire logic [7:0]         mem_rdata_i,
  input  wire logic [PC_W-1:0]    stack_top_i,
  input  wire logic               irq_pending_i,
  input  wire logic               mie_clear_i,
  output logic [7:0]              acc_o,
  output logic                    zero_flag_o,
  output logic                    mem_we_o,
  output logic [7:0]              mem_wdata_o,
  output logic                    stack_pop_o,
  output logic                    pc_load_o,
  output logic [PC_W-1:0]         pc_load_addr_o,
  output logic                    master_interrupt_enable_o,
  output logic                    irq_service_o,
  output logic                    exec_done_o
);

  logic [7:0]      acc_reg;
  logic            zero_reg;
  logic            mie_reg;
  logic            mem_we_reg;
  logic [7:0]      mem_wdata_reg;
  logic            pop_reg;
  logic [PC_W-1:0] pc_addr_reg;
  logic            irq_service_reg;
  logic            done_reg;
  logic            is_pop;
  logic            is_int_exit;
  logic            mie_next;

  orrx_alu_if dp ();

  assign dp.acc = acc_reg;
  assign dp.mem = mem_rdata_i;
  assign dp.imm = exec_imm_i;
  assign dp.op  = exec_op_i;

  orrx_alu u_alu (
    .dp (dp.alu)
  );

  assign is_int_exit = exec_valid_i && (exec_op_i == orrx_pkg::OP_INTERRUPT_EXIT);
  assign is_pop      = exec_valid_i &&
                       ((exec_op_i == orrx_pkg::OP_SUBROUTINE_EXIT) ||
                        (exec_op_i == orrx_pkg::OP_SUBROUTINE_EXIT_VALUE) ||
                        (exec_op_i == orrx_pkg::OP_INTERRUPT_EXIT));

  // The enable set by interrupt exit wins over a clear from the controller in the same cycle.
  always_comb begin
    mie_next = mie_reg;
    if (mie_clear_i) begin
      mie_next = 1'b0;
    end
    if (is_int_exit) begin
      mie_next = orrx_pkg::MIE_SET; // RL7
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc_reg  <= orrx_pkg::ACC_RST;
      zero_reg <= orrx_pkg::ZERO_RST;
    end else if (exec_valid_i) begin
      if (dp.acc_we) begin
        acc_reg <= dp.result; // RL2 RL3 RL6
      end
      if (dp.zero_we) begin
        zero_reg <= dp.zero; // RL10
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mem_we_reg    <= 1'b0;
      mem_wdata_reg <= orrx_pkg::BYTE_ZERO;
    end else begin
      mem_we_reg <= exec_valid_i && dp.mem_we; // RL4 RL9
      if (exec_valid_i && dp.mem_we) begin
        mem_wdata_reg <= dp.result;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pop_reg     <= 1'b0;
      pc_addr_reg <= '0;
    end else begin
      pop_reg <= is_pop; // RL5 RL6 RL7
      if (is_pop) begin
        pc_addr_reg <= stack_top_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mie_reg <= orrx_pkg::MIE_RST;
    end else begin
      mie_reg <= mie_next;
    end
  end

  // A pending request seen at interrupt exit is flagged in the same cycle as the new
  // program counter, so the sequencer vectors before fetching the resumed program.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_service_reg <= 1'b0;
    end else begin
      irq_service_reg <= is_int_exit && irq_pending_i; // RL8
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= exec_valid_i; // RL1
    end
  end

  assign acc_o                     = acc_reg;
  assign zero_flag_o               = zero_reg;
  assign mem_we_o                  = mem_we_reg;
  assign mem_wdata_o               = mem_wdata_reg;
  assign stack_pop_o               = pop_reg;
  assign pc_load_o                 = pop_reg;
  assign pc_load_addr_o            = pc_addr_reg;
  assign master_interrupt_enable_o = mie_reg;
  assign irq_service_o             = irq_service_reg;
  assign exec_done_o               = done_reg;

endmodule : orrx_exec

// ---- tb/orrx_exec_properties.sv ----
// Port assertions for the OR, return and rotate execution core.
`timescale 1ns/1ps
module orrx_chk #(parameter int PC_W = 12) (
  input logic               clk_i,
  input logic               sys_rst_i,
  input logic               exec_valid_i,
  input orrx_pkg::orrx_op_t exec_op_i,
  input logic [7:0]         exec_imm_i,
  input logic [7:0]         mem_rdata_i,
  input logic [PC_W-1:0]    stack_top_i,
  input logic               irq_pending_i,
  input logic [7:0]         acc_o,
  input logic               zero_flag_o,
  input logic               mem_we_o,
  input logic [7:0]         mem_wdata_o,
  input logic               pc_load_o,
  input logic [PC_W-1:0]    pc_load_addr_o,
  input logic               master_interrupt_enable_o,
  input logic               irq_service_o
);
  // One-hot view of the accepted opcode keeps every antecedent short.
  logic [7:0] g;
  logic [7:0] r;
  assign g = {8{exec_valid_i}} & (8'h01 << exec_op_i);
  assign r = {mem_rdata_i[6:0], mem_rdata_i[7]};
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_orm; g[1] |=> acc_o == ($past(acc_o) | $past(mem_rdata_i))
    && zero_flag_o == !acc_o && !mem_we_o; endproperty
  a_orm: assert property (p_orm) else $error("or mem");
  property p_ori; g[2] |=> acc_o == ($past(acc_o) | $past(exec_imm_i))
    && zero_flag_o == !acc_o; endproperty
  a_ori: assert property (p_ori) else $error("or imm");
  property p_otm; g[3] |=> mem_we_o && mem_wdata_o == ($past(acc_o) | $past(mem_rdata_i))
    && $stable(acc_o) && zero_flag_o == !mem_wdata_o; endproperty
  a_otm: assert property (p_otm) else $error("or to mem");
  property p_pop; g[4] |=> pc_load_o && pc_load_addr_o == $past(stack_top_i)
    && $stable(zero_flag_o) && $stable(acc_o); endproperty
  a_pop: assert property (p_pop) else $error("exit");
  property p_rv; g[5] |=> pc_load_o && acc_o == $past(exec_imm_i)
    && $stable(zero_flag_o); endproperty
  a_rv: assert property (p_rv) else $error("exit value");
  property p_mie; g[6] |=> pc_load_o && master_interrupt_enable_o
    && $stable(zero_flag_o); endproperty
  a_mie: assert property (p_mie) else $error("irq exit");
  property p_srv; g[6] |=> irq_service_o == $past(irq_pending_i); endproperty
  a_srv: assert property (p_srv) else $error("pending");
  property p_rot; g[7] |=> mem_we_o && mem_wdata_o == $past(r)
    && $stable(zero_flag_o) && $stable(acc_o); endproperty
  a_rot: assert property (p_rot) else $error("rotate");
  property p_idl; g[0] |=> $stable(acc_o) && $stable(zero_flag_o) && !mem_we_o
    && !pc_load_o && !irq_service_o; endproperty
  a_idl: assert property (p_idl) else $error("idle");
endmodule : orrx_chk
bind orrx_exec orrx_chk #(.PC_W(PC_W)) i_chk (.*);

// ---- tb/tb_top.sv ----
// Random and corner-case bench for the OR, return and rotate execution core.
`timescale 1ns/1ps
module tb_top;
  logic               clk_i = 1'b0;
  logic               sys_rst_i, exec_valid_i, irq_pending_i, mie_clear_i;
  orrx_pkg::orrx_op_t exec_op_i;
  logic [7:0]         exec_imm_i, mem_rdata_i, acc_o, mem_wdata_o, ea, ew;
  logic [11:0]        stack_top_i, pc_load_addr_o, es;
  logic               zero_flag_o, mem_we_o, stack_pop_o, pc_load_o, irq_service_o;
  logic               exec_done_o, master_interrupt_enable_o, ez, ewe, ep, em, ei, ed;
  int                 n_mismatch = 0;
  int                 n_checks = 0;
  orrx_exec #(.PC_W(12)) i_dut (.*);
  initial forever #2 clk_i = ~clk_i;
  function automatic logic [7:0] rot(input logic [7:0] b);
    return {b[6:0], b[7]};
  endfunction : rot
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // Zero operands are drawn often, otherwise the zero flag would almost never be set.
  task automatic run(input int n, input bit cz);
    logic [7:0]  m, x;
    logic [11:0] s;
    logic [2:0]  op;
    logic        v, p, c;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      v = cz | ($urandom % 4 != 0);
      op = cz ? 3'(i) : 3'($urandom);
      m = (cz || $urandom % 3 == 0) ? 8'h00 : 8'($urandom);
      x = (cz || $urandom % 3 == 0) ? 8'h00 : 8'($urandom);
      s = 12'($urandom);
      p = 1'($urandom);
      c = $urandom % 8 == 0;
      exec_valid_i <= v;
      exec_op_i <= orrx_pkg::orrx_op_t'(op);
      exec_imm_i <= x;
      mem_rdata_i <= m;
      stack_top_i <= s;
      irq_pending_i <= p;
      mie_clear_i <= c;
      #1;
      chk({acc_o, zero_flag_o, master_interrupt_enable_o}, {ea, ez, em});
      chk({mem_we_o, exec_done_o, mem_wdata_o}, {ewe, ed, ew});
      chk({stack_pop_o, pc_load_o, pc_load_addr_o, irq_service_o}, {ep, ep, es, ei});
      {ewe, ep, ei, ed} = {3'h0, v};
      if (c) em = 1'b0;
      if (v) case (op)
        3'h0: ;
        3'h1: ea = ea | m;
        3'h2: ea = ea | x;
        3'h3: ew = ea | m;
        3'h7: ew = rot(m);
        default: {ep, es} = {1'b1, s};
      endcase
      if (v && op inside {3'h1, 3'h2}) ez = ea == 8'h00;
      if (v && op == 3'h3) ez = ew == 8'h00;
      if (v && op inside {3'h3, 3'h7}) ewe = 1'b1;
      if (v && op == 3'h5) ea = x;
      if (v && op == 3'h6) {em, ei} = {1'b1, p};
    end
  endtask : run
  initial begin
    {sys_rst_i, exec_valid_i, irq_pending_i, mie_clear_i} = 4'h8;
    exec_op_i = orrx_pkg::OP_IDLE_INSTRUCTION;
    {exec_imm_i, mem_rdata_i, stack_top_i, ea, ew, es} = 56'h0;
    {ez, ewe, ep, em, ei, ed} = 6'h0;
    void'($urandom(88892));
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    run(16, 1'b1);
    $display("corner test done");
    run(3000, 1'b0);
    $display("random test done");
    conclude();
  end
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end
endmodule : tb_top
